// File: core/lcd_cmd_decode.sv
// Behaviour
// RULE1 - Commands decode from CS_n, CA0-CA3 and CKE at the rising edge.
// RULE2 - One cycle per command: rising CA word, then falling CA word.
// RULE3 - Mode register write carries an 8-bit address and 8-bit operand.
// RULE4 - Mode register read carries an 8-bit address.
// RULE5 - Activate carries bank and a fifteen-bit row over both edges.
// RULE6 - Read and write carry bank, column and auto-precharge flag.
// RULE7 - Column bit zero is never sent and is taken as zero.
// RULE8 - Auto-precharge closes the bank after the access completes.
// RULE9 - Precharge closes one bank, or all banks when the flag is set.
// RULE10 - Refresh per bank or all banks; self-refresh uses CKE falling.
// RULE11 - Burst terminate, two NOP forms and deep power-down entry encodings.
// RULE12 - CKE falling enters power-down by state; CKE rising exits.
// RULE13 - Controller sends only NOP until exit times elapse.
// RULE14 - Controller toggles the clock twice within exit intervals.
// RULE15 - Self-refresh and deep power-down exit seen without clock edge.
// RULE16 - Resetting power-down exit goes idle only after the init interval.
// RULE17 - Idle and active banks accept only their listed commands.
// RULE18 - New access restarts a burst; burst terminate returns to active.
// RULE19 - Controller leaves a bank alone in its transitional states.
// RULE20 - Controller sends only NOP during refresh and mode register states.
// RULE21 - Refresh and mode register states expire back to their prior state; only MRR does here, MRW and refresh always expire to normal.
// RULE22 - Controller issues no undefined command or CKE sequence.
// RULE23 - Burst terminate only while a burst runs.
// RULE24 - Refresh, self-refresh entry and MRW only with all banks idle.
// RULE25 - Each timed state counts cycles then advances.
`timescale 1ns/1ps
`default_nettype none
module lcd_cmd_decode #(
  parameter int NUM_BANKS = lcd_pkg::NUM_BANKS
) (
  input  wire logic                        core_clk,
  input  wire logic                        reset,
  input  wire logic                        link_clk,
  input  wire logic                        cke,
  input  wire logic                        cs_n,
  input  wire logic [lcd_pkg::CA_W-1:0]    ca,
  output var  logic                        cmd_vld_ff,
  output var  lcd_pkg::lcd_cmd_s           cmd_ff,
  output var  lcd_pkg::lcd_dev_e           dev_state_ff,
  output var  logic [NUM_BANKS*4-1:0]      bank_state_ff,
  output var  logic                        any_open_ff,
  output var  logic                        illegal_ff
);

  logic                     link_tgl;
  lcd_pkg::lcd_cmd_s        link_cmd;
  logic [2:0]               tgl_sync_ff;
  logic [1:0]               cke_sync_ff;
  logic [lcd_pkg::CNT_W-1:0] dcnt_ff;
  logic [lcd_pkg::CNT_W-1:0] nxt_dcnt;
  logic [lcd_pkg::CNT_W-1:0] init_cnt_ff;
  lcd_pkg::lcd_dev_e        nxt_dev;
  lcd_pkg::lcd_dev_e        mrr_ret_ff;
  lcd_pkg::lcd_dev_e        nxt_ret;
  lcd_pkg::lcd_cmd_s        cmd_hold_ff;
  lcd_pkg::lcd_bank_e       bank_st [NUM_BANKS];
  logic [NUM_BANKS-1:0]     open_vec;
  logic [NUM_BANKS-1:0]     busy_vec;
  logic                     nxt_illegal;

  lcd_ca_capture u_cap (
    .link_clk (link_clk),
    .reset    (reset),
    .cke      (cke),
    .cs_n     (cs_n),
    .ca       (ca),
    .tgl_ff   (link_tgl),
    .cmd_ff   (link_cmd)
  );

  // Real commands closer than about three core cycles apart would be lost.
  wire logic new_cmd = tgl_sync_ff[2] ^ tgl_sync_ff[1];
  wire lcd_pkg::lcd_cmd_e c = cmd_hold_ff.cmd;
  wire logic in_normal  = dev_state_ff == lcd_pkg::LCD_D_NORMAL;
  wire logic in_reset   = dev_state_ff == lcd_pkg::LCD_D_RESETTING;
  wire logic all_idle   = ~|open_vec && ~|busy_vec;
  wire logic init_done  = init_cnt_ff == '0;
  wire logic cke_lvl    = cke_sync_ff[1];
  wire logic mr_busy    = dev_state_ff == lcd_pkg::LCD_D_MR_WRITING ||
                          dev_state_ff == lcd_pkg::LCD_D_MR_READING ||
                          dev_state_ff == lcd_pkg::LCD_D_REF_ALL;
  wire logic bank_cmd_ok = cmd_vld_ff && in_normal;
  wire logic force_idle  = dev_state_ff == lcd_pkg::LCD_D_DEEP_PD ||
                           dev_state_ff == lcd_pkg::LCD_D_POWER_ON;

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      tgl_sync_ff <= '0;
      cke_sync_ff <= '0;
      cmd_vld_ff  <= 1'b0;
      cmd_hold_ff <= '0;
    end
    else
    begin
      tgl_sync_ff <= {tgl_sync_ff[1:0], link_tgl};
      cke_sync_ff <= {cke_sync_ff[0], cke};
      cmd_vld_ff  <= new_cmd;
      if (new_cmd)
        cmd_hold_ff <= link_cmd;
    end
  end

  always_comb
  begin
    cmd_ff = cmd_hold_ff;
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_BANKS; gi++)
    begin : g_bank
      wire logic hit = cmd_hold_ff.bank == lcd_pkg::BANK_W'(gi);
      lcd_bank_fsm u_bank (
        .core_clk   (core_clk),
        .reset      (reset),
        .cmd_vld    (bank_cmd_ok),
        .cmd        (cmd_hold_ff),
        .hit        (hit),
        .force_idle (force_idle),
        .state_ff   (bank_st[gi])
      );
      assign open_vec[gi] = bank_st[gi] != lcd_pkg::LCD_B_IDLE &&
                            bank_st[gi] != lcd_pkg::LCD_B_REFRESHING &&
                            bank_st[gi] != lcd_pkg::LCD_B_PRECHARGING;
      assign busy_vec[gi] = bank_st[gi] == lcd_pkg::LCD_B_REFRESHING ||
                            bank_st[gi] == lcd_pkg::LCD_B_PRECHARGING;
      always_ff @(posedge core_clk or posedge reset)
      begin
        if (reset)
          bank_state_ff[gi*4 +: 4] <= '0;
        else
          bank_state_ff[gi*4 +: 4] <= bank_st[gi];
      end
    end
  endgenerate

  always_comb
  begin
    nxt_dev     = dev_state_ff;
    nxt_ret     = mrr_ret_ff;
    nxt_dcnt    = (dcnt_ff == '0) ? dcnt_ff : dcnt_ff - 1'b1; // RULE25
    nxt_illegal = 1'b0;
    case (dev_state_ff)
      lcd_pkg::LCD_D_POWER_ON:
        if (cmd_vld_ff && c == lcd_pkg::LCD_CMD_MRW)
          nxt_dev = lcd_pkg::LCD_D_RESETTING; // RULE17
      lcd_pkg::LCD_D_RESETTING, lcd_pkg::LCD_D_NORMAL:
        if (cmd_vld_ff)
          case (c)
            lcd_pkg::LCD_CMD_MRW:
              if (all_idle)
              begin
                nxt_dev  = lcd_pkg::LCD_D_MR_WRITING; // RULE17
                nxt_dcnt = lcd_pkg::CNT_W'(lcd_pkg::T_MRW_CYC);
              end
            lcd_pkg::LCD_CMD_MRR:
            begin
              nxt_ret  = dev_state_ff; // RULE21
              nxt_dev  = lcd_pkg::LCD_D_MR_READING; // RULE17
              nxt_dcnt = lcd_pkg::CNT_W'(lcd_pkg::T_MRR_CYC);
            end
            lcd_pkg::LCD_CMD_REFAB:
              if (in_normal && all_idle)
              begin
                nxt_dev  = lcd_pkg::LCD_D_REF_ALL; // RULE17
                nxt_dcnt = lcd_pkg::CNT_W'(lcd_pkg::T_RFCAB_CYC);
              end
            lcd_pkg::LCD_CMD_PDE:
              if (in_reset)
                nxt_dev = lcd_pkg::LCD_D_RST_PD; // RULE12
              else
                nxt_dev = (|open_vec) ? lcd_pkg::LCD_D_ACT_PD
                                      : lcd_pkg::LCD_D_IDLE_PD; // RULE12
            lcd_pkg::LCD_CMD_SREF:
              if (in_normal && all_idle)
                nxt_dev = lcd_pkg::LCD_D_SELF_REF; // RULE10
            lcd_pkg::LCD_CMD_DPD:
              if (all_idle)
                nxt_dev = lcd_pkg::LCD_D_DEEP_PD; // RULE11
            lcd_pkg::LCD_CMD_PDX:
              nxt_illegal = 1'b1;
            default:
              nxt_illegal = in_reset && c != lcd_pkg::LCD_CMD_MRR;
          endcase
      lcd_pkg::LCD_D_MR_WRITING, lcd_pkg::LCD_D_MR_READING,
      lcd_pkg::LCD_D_REF_ALL:
        if (dcnt_ff == '0)
        begin
          if (dev_state_ff == lcd_pkg::LCD_D_MR_READING)
            nxt_dev = mrr_ret_ff; // RULE21
          else
            nxt_dev = lcd_pkg::LCD_D_NORMAL; // RULE21
        end
      lcd_pkg::LCD_D_ACT_PD, lcd_pkg::LCD_D_IDLE_PD:
        if (cmd_vld_ff && c == lcd_pkg::LCD_CMD_PDX)
          nxt_dev = lcd_pkg::LCD_D_NORMAL; // RULE12
      lcd_pkg::LCD_D_RST_PD:
        if (cmd_vld_ff && c == lcd_pkg::LCD_CMD_PDX)
          nxt_dev = init_done ? lcd_pkg::LCD_D_NORMAL
                              : lcd_pkg::LCD_D_RESETTING; // RULE16
      lcd_pkg::LCD_D_SELF_REF:
        if (cke_lvl)
          nxt_dev = lcd_pkg::LCD_D_NORMAL; // RULE15
      lcd_pkg::LCD_D_DEEP_PD:
        if (cke_lvl)
          nxt_dev = lcd_pkg::LCD_D_POWER_ON; // RULE15
      default:
        nxt_dev = lcd_pkg::LCD_D_POWER_ON;
    endcase
    if (mr_busy && cmd_vld_ff)
      nxt_illegal = 1'b1;
  end

  // Exit from self-refresh and deep power-down follows the CKE level itself,
  // not a link edge, because the link clock may be stopped in those modes.
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      dev_state_ff <= lcd_pkg::LCD_D_POWER_ON;
      mrr_ret_ff   <= lcd_pkg::LCD_D_NORMAL;
      dcnt_ff      <= '0;
      init_cnt_ff  <= lcd_pkg::CNT_W'(lcd_pkg::T_INIT5_CYC);
      any_open_ff  <= 1'b0;
      illegal_ff   <= 1'b0;
    end
    else
    begin
      dev_state_ff <= nxt_dev;
      mrr_ret_ff   <= nxt_ret;
      dcnt_ff      <= nxt_dcnt;
      any_open_ff  <= |open_vec;
      illegal_ff   <= nxt_illegal;
      if (dev_state_ff == lcd_pkg::LCD_D_POWER_ON)
        init_cnt_ff <= lcd_pkg::CNT_W'(lcd_pkg::T_INIT5_CYC);
      else if (!init_done)
        init_cnt_ff <= init_cnt_ff - 1'b1; // RULE16
    end
  end

endmodule : lcd_cmd_decode
`default_nettype wire

// File: core/lcd_pkg.sv
package lcd_pkg;

  localparam int NUM_BANKS = 8;
  localparam int BANK_W    = 3;
  localparam int CA_W      = 10;

  // Timing limits in core clock cycles (defaults, 4 ns period).
  localparam int T_RCD_CYC   = 5;
  localparam int T_RP_CYC    = 5;
  localparam int T_RFCPB_CYC = 15;
  localparam int T_RFCAB_CYC = 33;
  localparam int T_MRW_CYC   = 5;
  localparam int T_MRR_CYC   = 2;
  localparam int T_BURST_CYC = 64;
  localparam int T_INIT5_CYC = 16;
  localparam int CNT_W       = 8;

  typedef enum logic [3:0] {
    LCD_CMD_NOP,
    LCD_CMD_MRW,
    LCD_CMD_MRR,
    LCD_CMD_REFPB,
    LCD_CMD_REFAB,
    LCD_CMD_ACT,
    LCD_CMD_WR,
    LCD_CMD_RD,
    LCD_CMD_PRE,
    LCD_CMD_BST,
    LCD_CMD_SREF,
    LCD_CMD_DPD,
    LCD_CMD_PDE,
    LCD_CMD_PDX
  } lcd_cmd_e;

  typedef enum logic [3:0] {
    LCD_B_IDLE,
    LCD_B_ACTIVATING,
    LCD_B_ACTIVE,
    LCD_B_READING,
    LCD_B_WRITING,
    LCD_B_RD_AP,
    LCD_B_WR_AP,
    LCD_B_PRECHARGING,
    LCD_B_REFRESHING
  } lcd_bank_e;

  typedef enum logic [3:0] {
    LCD_D_POWER_ON,
    LCD_D_RESETTING,
    LCD_D_NORMAL,
    LCD_D_MR_WRITING,
    LCD_D_MR_READING,
    LCD_D_REF_ALL,
    LCD_D_ACT_PD,
    LCD_D_IDLE_PD,
    LCD_D_RST_PD,
    LCD_D_SELF_REF,
    LCD_D_DEEP_PD
  } lcd_dev_e;

  typedef struct packed {
    lcd_cmd_e             cmd;
    logic [BANK_W-1:0]    bank;
    logic                 ab;
    logic                 ap;
    logic [14:0]          row;
    logic [11:0]          col;
    logic [7:0]           mr_addr;
    logic [7:0]           mr_op;
  } lcd_cmd_s;

endpackage : lcd_pkg

// File: core/lcd_ca_capture.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_ca_capture (
  input  wire logic                      link_clk,
  input  wire logic                      reset,
  input  wire logic                      cke,
  input  wire logic                      cs_n,
  input  wire logic [lcd_pkg::CA_W-1:0]  ca,
  output var  logic                      tgl_ff,
  output var  lcd_pkg::lcd_cmd_s         cmd_ff
);

  logic [lcd_pkg::CA_W-1:0] rise_ca_ff;
  logic                     rise_cs_n_ff;
  logic                     rise_cke_ff;
  logic                     prev_cke_ff;
  logic                     have_ff;
  lcd_pkg::lcd_cmd_s        nxt_cmd;
  wire logic [lcd_pkg::CA_W-1:0] r = rise_ca_ff;

  always_ff @(posedge link_clk or posedge reset)
  begin
    if (reset)
    begin
      rise_ca_ff   <= '0;
      rise_cs_n_ff <= 1'b1;
      // Idle CKE level, so reset release shows no false exit.
      rise_cke_ff  <= 1'b1;
      prev_cke_ff  <= 1'b1;
      have_ff      <= 1'b0;
    end
    else
    begin
      rise_ca_ff   <= ca; // RULE2
      rise_cs_n_ff <= cs_n; // RULE1
      rise_cke_ff  <= cke; // RULE1
      prev_cke_ff  <= rise_cke_ff;
      have_ff      <= 1'b1;
    end
  end

  // Decode uses the rising word plus the falling word of the same cycle.
  always_comb
  begin
    nxt_cmd         = '0;
    nxt_cmd.cmd     = lcd_pkg::LCD_CMD_NOP;
    nxt_cmd.bank    = r[9:7];
    nxt_cmd.ab      = r[4];
    nxt_cmd.ap      = ca[0];
    nxt_cmd.row     = {ca[9], ca[8], r[6:2], ca[7:0]}; // RULE5
    nxt_cmd.col     = {ca[9:1], r[6:5], 1'b0}; // RULE6 RULE7
    nxt_cmd.mr_addr = {ca[1:0], r[9:4]}; // RULE3 RULE4
    nxt_cmd.mr_op   = ca[9:2]; // RULE3
    if (prev_cke_ff && !rise_cke_ff)
    begin
      if (rise_cs_n_ff)
        nxt_cmd.cmd = lcd_pkg::LCD_CMD_PDE; // RULE12
      else if (r[2:0] == 3'h4)
        nxt_cmd.cmd = lcd_pkg::LCD_CMD_SREF; // RULE10
      else if (r[2:0] == 3'h3)
        nxt_cmd.cmd = lcd_pkg::LCD_CMD_DPD; // RULE11
    end
    else if (!prev_cke_ff && rise_cke_ff && rise_cs_n_ff)
      nxt_cmd.cmd = lcd_pkg::LCD_CMD_PDX; // RULE12
    else if (prev_cke_ff && rise_cke_ff && !rise_cs_n_ff)
    begin
      if (r[1:0] == 2'h2)
        nxt_cmd.cmd = lcd_pkg::LCD_CMD_ACT; // RULE5
      else if (r[1:0] == 2'h1)
        nxt_cmd.cmd = r[2] ? lcd_pkg::LCD_CMD_RD : lcd_pkg::LCD_CMD_WR; // RULE6
      else if (r[3:0] == 4'h0)
        nxt_cmd.cmd = lcd_pkg::LCD_CMD_MRW; // RULE3
      else if (r[3:0] == 4'h8)
        nxt_cmd.cmd = lcd_pkg::LCD_CMD_MRR; // RULE4
      else if (r[3:0] == 4'h4)
        nxt_cmd.cmd = lcd_pkg::LCD_CMD_REFPB; // RULE10
      else if (r[3:0] == 4'hC)
        nxt_cmd.cmd = lcd_pkg::LCD_CMD_REFAB; // RULE10
      else if (r[3:0] == 4'hB)
        nxt_cmd.cmd = lcd_pkg::LCD_CMD_PRE; // RULE9
      else if (r[3:0] == 4'h3)
        nxt_cmd.cmd = lcd_pkg::LCD_CMD_BST; // RULE11
    end
  end

  // Falling edge completes the command; a toggle hands it to the core clock.
  always_ff @(negedge link_clk or posedge reset)
  begin
    if (reset)
    begin
      cmd_ff       <= '0;
      tgl_ff       <= 1'b0;
    end
    else
    begin
      if (have_ff && nxt_cmd.cmd != lcd_pkg::LCD_CMD_NOP)
      begin
        cmd_ff <= nxt_cmd; // RULE2
        tgl_ff <= ~tgl_ff;
      end
    end
  end

endmodule : lcd_ca_capture
`default_nettype wire

// File: core/lcd_bank_fsm.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_bank_fsm (
  input  wire logic                      core_clk,
  input  wire logic                      reset,
  input  wire logic                      cmd_vld,
  input  wire lcd_pkg::lcd_cmd_s         cmd,
  input  wire logic                      hit,
  input  wire logic                      force_idle,
  output var  lcd_pkg::lcd_bank_e        state_ff
);

  logic [lcd_pkg::CNT_W-1:0] cnt_ff;
  logic [lcd_pkg::CNT_W-1:0] nxt_cnt;
  lcd_pkg::lcd_bank_e        nxt_state;
  wire logic sel  = cmd_vld && hit;
  wire logic pall = cmd_vld && cmd.cmd == lcd_pkg::LCD_CMD_PRE && cmd.ab;
  wire logic done = cnt_ff == '0;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt   = done ? cnt_ff : cnt_ff - 1'b1; // RULE25
    if (force_idle)
    begin
      nxt_state = lcd_pkg::LCD_B_IDLE;
      nxt_cnt   = '0;
    end
    else if (pall && state_ff != lcd_pkg::LCD_B_REFRESHING)
    begin
      nxt_state = lcd_pkg::LCD_B_PRECHARGING; // RULE9
      nxt_cnt   = lcd_pkg::CNT_W'(lcd_pkg::T_RP_CYC);
    end
    else
      case (state_ff)
        lcd_pkg::LCD_B_IDLE:
          if (sel && cmd.cmd == lcd_pkg::LCD_CMD_ACT)
          begin
            nxt_state = lcd_pkg::LCD_B_ACTIVATING; // RULE17
            nxt_cnt   = lcd_pkg::CNT_W'(lcd_pkg::T_RCD_CYC);
          end
          else if (sel && cmd.cmd == lcd_pkg::LCD_CMD_REFPB)
          begin
            nxt_state = lcd_pkg::LCD_B_REFRESHING; // RULE17
            nxt_cnt   = lcd_pkg::CNT_W'(lcd_pkg::T_RFCPB_CYC);
          end
          else if (sel && cmd.cmd == lcd_pkg::LCD_CMD_PRE)
          begin
            nxt_state = lcd_pkg::LCD_B_PRECHARGING; // RULE17
            nxt_cnt   = lcd_pkg::CNT_W'(lcd_pkg::T_RP_CYC);
          end
        lcd_pkg::LCD_B_ACTIVATING, lcd_pkg::LCD_B_PRECHARGING,
        lcd_pkg::LCD_B_REFRESHING:
          if (done)
            nxt_state = (state_ff == lcd_pkg::LCD_B_ACTIVATING) ?
                        lcd_pkg::LCD_B_ACTIVE : lcd_pkg::LCD_B_IDLE; // RULE21
        lcd_pkg::LCD_B_ACTIVE, lcd_pkg::LCD_B_READING,
        lcd_pkg::LCD_B_WRITING:
          if (sel && (cmd.cmd == lcd_pkg::LCD_CMD_RD ||
                      cmd.cmd == lcd_pkg::LCD_CMD_WR))
          begin
            // A new access restarts the burst.
            nxt_cnt = lcd_pkg::CNT_W'(lcd_pkg::T_BURST_CYC); // RULE18
            if (cmd.ap)
              nxt_state = (cmd.cmd == lcd_pkg::LCD_CMD_RD) ?
                          lcd_pkg::LCD_B_RD_AP : lcd_pkg::LCD_B_WR_AP;
            else
              nxt_state = (cmd.cmd == lcd_pkg::LCD_CMD_RD) ?
                          lcd_pkg::LCD_B_READING : lcd_pkg::LCD_B_WRITING;
          end
          else if (sel && cmd.cmd == lcd_pkg::LCD_CMD_PRE)
          begin
            nxt_state = lcd_pkg::LCD_B_PRECHARGING; // RULE17
            nxt_cnt   = lcd_pkg::CNT_W'(lcd_pkg::T_RP_CYC);
          end
          else if (state_ff != lcd_pkg::LCD_B_ACTIVE && (done ||
                   (cmd_vld && cmd.cmd == lcd_pkg::LCD_CMD_BST)))
            nxt_state = lcd_pkg::LCD_B_ACTIVE; // RULE18
        lcd_pkg::LCD_B_RD_AP, lcd_pkg::LCD_B_WR_AP:
          if (done)
          begin
            nxt_state = lcd_pkg::LCD_B_PRECHARGING; // RULE8
            nxt_cnt   = lcd_pkg::CNT_W'(lcd_pkg::T_RP_CYC);
          end
        default:
          nxt_state = lcd_pkg::LCD_B_IDLE;
      endcase
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      state_ff <= lcd_pkg::LCD_B_IDLE;
      cnt_ff   <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

endmodule : lcd_bank_fsm
`default_nettype wire

// File: testbench/lcd_cmd_decode_sva.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_cmd_decode_sva #(
  parameter int NUM_BANKS = lcd_pkg::NUM_BANKS
) (
  input wire logic                      core_clk,
  input wire logic                      reset,
  input wire logic                      cke,
  input wire logic                      cmd_vld_ff,
  input wire lcd_pkg::lcd_cmd_s         cmd_ff,
  input wire lcd_pkg::lcd_dev_e         dev_state_ff,
  input wire logic [NUM_BANKS*4-1:0]    bank_state_ff,
  input wire logic                      any_open_ff,
  input wire logic                      illegal_ff
);
  localparam int RCD_LO = lcd_pkg::T_RCD_CYC - 2;
  localparam int RFC_LO = lcd_pkg::T_RFCAB_CYC - 2;
  localparam int MRW_LO = lcd_pkg::T_MRW_CYC - 2;
  logic [3:0]                           cur_b;
  // The bank of the latest command is the one whose timers matter.
  assign cur_b = bank_state_ff[4*cmd_ff.bank +: 4];
  property p_vld; @(posedge core_clk) disable iff (reset)
    cmd_vld_ff |=> !cmd_vld_ff;
  endproperty
  a_vld: assert property (p_vld) else $error("valid pulse too long");
  property p_nop; @(posedge core_clk) disable iff (reset)
    cmd_vld_ff |-> cmd_ff.cmd != lcd_pkg::LCD_CMD_NOP;
  endproperty
  a_nop: assert property (p_nop) else $error("idle cycle reported");
  property p_col; @(posedge core_clk) disable iff (reset)
    cmd_vld_ff && cmd_ff.cmd inside {lcd_pkg::LCD_CMD_RD, lcd_pkg::LCD_CMD_WR}
      |-> cmd_ff.col[0] == 1'h0;
  endproperty
  a_col: assert property (p_col) else $error("column bit zero set");
  property p_rcd; @(posedge core_clk) disable iff (reset)
    $rose(cur_b == lcd_pkg::LCD_B_ACTIVATING) |-> ##RCD_LO
      cur_b == lcd_pkg::LCD_B_ACTIVATING ##[1:6] cur_b == lcd_pkg::LCD_B_ACTIVE;
  endproperty
  a_rcd: assert property (p_rcd) else $error("activation time wrong");
  property p_rfc; @(posedge core_clk) disable iff (reset)
    $rose(dev_state_ff == lcd_pkg::LCD_D_REF_ALL) |-> ##RFC_LO
      dev_state_ff == lcd_pkg::LCD_D_REF_ALL ##[1:6]
      dev_state_ff == lcd_pkg::LCD_D_NORMAL;
  endproperty
  a_rfc: assert property (p_rfc) else $error("refresh time wrong");
  property p_mrw; @(posedge core_clk) disable iff (reset)
    $rose(dev_state_ff == lcd_pkg::LCD_D_MR_WRITING) |-> ##MRW_LO
      dev_state_ff == lcd_pkg::LCD_D_MR_WRITING ##[1:6] dev_state_ff inside
      {lcd_pkg::LCD_D_RESETTING, lcd_pkg::LCD_D_NORMAL};
  endproperty
  a_mrw: assert property (p_mrw) else $error("mode write time wrong");
  property p_pd; @(posedge core_clk) disable iff (reset)
    dev_state_ff inside {lcd_pkg::LCD_D_ACT_PD, lcd_pkg::LCD_D_IDLE_PD}
      |-> any_open_ff == (dev_state_ff == lcd_pkg::LCD_D_ACT_PD);
  endproperty
  a_pd: assert property (p_pd) else $error("wrong power-down kind");
  property p_srx; @(posedge core_clk) disable iff (reset)
    dev_state_ff == lcd_pkg::LCD_D_SELF_REF && cke
      |-> ##[1:12] dev_state_ff == lcd_pkg::LCD_D_NORMAL;
  endproperty
  a_srx: assert property (p_srx) else $error("self refresh not left");
  property p_ill; @(posedge core_clk) disable iff (reset)
    illegal_ff |=> !illegal_ff;
  endproperty
  a_ill: assert property (p_ill) else $error("illegal flag too long");
  c_sr: cover property (@(posedge core_clk)
    $rose(dev_state_ff == lcd_pkg::LCD_D_SELF_REF));
  c_ill: cover property (@(posedge core_clk) illegal_ff);
  c_ap: cover property (@(posedge core_clk) cmd_vld_ff && cmd_ff.ap);
endmodule : lcd_cmd_decode_sva
bind lcd_cmd_decode lcd_cmd_decode_sva #(.NUM_BANKS(NUM_BANKS)) i_sva (
  .core_clk(core_clk), .reset(reset), .cke(cke), .cmd_vld_ff(cmd_vld_ff),
  .cmd_ff(cmd_ff), .dev_state_ff(dev_state_ff),
  .bank_state_ff(bank_state_ff), .any_open_ff(any_open_ff),
  .illegal_ff(illegal_ff)
);
`default_nettype wire

// File: testbench/lcd_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_ctl_model (
  output var logic                      link_clk,
  output var logic                      cke,
  output var logic                      cs_n,
  output var logic [lcd_pkg::CA_W-1:0]  ca
);
  initial
  begin
    link_clk = 1'h0;
    cke = 1'h1;
    cs_n = 1'h1;
    ca = '0;
    #5.3;
    forever #16 link_clk = ~link_clk;
  end
  // One command cycle; the bus shows the inverse word once released.
  task automatic send(input logic k, input logic cs,
                      input logic [lcd_pkg::CA_W-1:0] r,
                      input logic [lcd_pkg::CA_W-1:0] f);
    @(negedge link_clk);
    cke <= k;
    cs_n <= cs;
    ca <= r;
    @(posedge link_clk);
    ca <= f;
    @(negedge link_clk);
    cs_n <= 1'h1;
    ca <= ~f;
    repeat (2) @(posedge link_clk);
  endtask : send
endmodule : lcd_ctl_model
`default_nettype wire

// File: testbench/lcd_cmd_decode_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module lcd_cmd_decode_tb_top;
  logic                            core_clk;
  logic                            reset;
  wire logic                       link_clk;
  wire logic                       cke;
  wire logic                       cs_n;
  wire logic [lcd_pkg::CA_W-1:0]   ca;
  logic                            cmd_vld_ff;
  logic                            any_open_ff;
  logic                            illegal_ff;
  lcd_pkg::lcd_cmd_s               cmd_ff;
  lcd_pkg::lcd_cmd_s               got;
  lcd_pkg::lcd_dev_e               dev_state_ff;
  logic [lcd_pkg::NUM_BANKS*4-1:0] bank_state_ff;
  logic [31:0]                     rv;
  int                              miscompares;
  int                              cmp_count;
  int                              cyc;
  int                              bsel;
  int                              seed;
  lcd_ctl_model i_ctl (.link_clk(link_clk), .cke(cke), .cs_n(cs_n), .ca(ca));
  lcd_cmd_decode i_dut (
    .core_clk(core_clk), .reset(reset), .link_clk(link_clk), .cke(cke),
    .cs_n(cs_n), .ca(ca), .cmd_vld_ff(cmd_vld_ff), .cmd_ff(cmd_ff),
    .dev_state_ff(dev_state_ff), .bank_state_ff(bank_state_ff),
    .any_open_ff(any_open_ff), .illegal_ff(illegal_ff));
  initial core_clk = 1'h0;
  always #2 core_clk = ~core_clk;
  task automatic tally_and_finish();
    $display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
    begin
      $display("ALL TESTS PASSED");
    end
    else
    begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  function automatic logic [31:0] probe(input int sel);
    case (sel)
      0: return 32'(dev_state_ff);
      1: return 32'(bank_state_ff[4*bsel +: 4]);
      2: return 32'(bank_state_ff);
      default: return 32'(illegal_ff);
    endcase
  endfunction : probe
  // States are polled at the falling core edge, where they have settled.
  task automatic wait_for(input int sel, input logic [31:0] e);
    int n = 0;
    while (probe(sel) !== e && n < 400)
    begin
      @(negedge core_clk);
      n++;
    end
    chk(probe(sel), e);
  endtask : wait_for
  task automatic issue(input logic k, input logic [9:0] r, input logic [9:0] f);
    int n = 0;
    fork
      i_ctl.send(k, 1'h0, r, f);
      while (cmd_vld_ff !== 1'h1 && n < 100)
      begin
        @(negedge core_clk);
        n++;
      end
    join
    got = cmd_ff;
    chk(32'(n < 100), 32'h1);
  endtask : issue
  task automatic pwr(input logic k);
    i_ctl.send(k, 1'h1, rv[9:0], rv[19:10]);
  endtask : pwr
  task automatic act();
    rv = $random(seed);
    bsel = rv[2:0];
    issue(1'h1, {rv[2:0], rv[7:3], 2'h2}, rv[17:8]);
    chk(got.cmd, lcd_pkg::LCD_CMD_ACT);
    chk(got.row, {rv[17:16], rv[7:3], rv[15:8]});
    chk(got.bank, rv[2:0]);
    wait_for(1, lcd_pkg::LCD_B_ACTIVE);
  endtask : act
  initial
  begin
    reset = 1'h1;
    seed = 32'hB633B991;
    repeat (12) @(posedge core_clk);
    reset <= 1'h0;
    repeat (2) @(posedge link_clk);
    chk(dev_state_ff, lcd_pkg::LCD_D_POWER_ON);
    rv = $random(seed);
    issue(1'h1, {rv[5:0], 4'h0}, rv[15:6]);
    chk(got.mr_addr, rv[7:0]);
    chk(got.mr_op, rv[15:8]);
    wait_for(0, lcd_pkg::LCD_D_RESETTING);
    rv = $random(seed);
    issue(1'h1, {rv[5:0], 4'h8}, rv[15:6]);
    chk(got.cmd, lcd_pkg::LCD_CMD_MRR);
    chk(got.mr_addr, rv[7:0]);
    pwr(1'h0);
    wait_for(0, lcd_pkg::LCD_D_RST_PD);
    pwr(1'h1);
    wait_for(0, lcd_pkg::LCD_D_NORMAL);
    for (int i = 0; i < 4; i++)
    begin
      act();
      rv = $random(seed);
      issue(1'h1, {bsel[2:0], rv[1:0], rv[3:2], i[0], 2'h1}, {rv[12:4], i[1]});
      chk(got.cmd, i[0] ? lcd_pkg::LCD_CMD_RD : lcd_pkg::LCD_CMD_WR);
      chk(got.ap, i[1]);
      chk(got.col, {rv[12:4], rv[1:0], 1'h0});
      if (i[1])
      begin
        wait_for(1, lcd_pkg::LCD_B_IDLE);
      end
      else
      begin
        wait_for(1, i[0] ? lcd_pkg::LCD_B_READING
                         : lcd_pkg::LCD_B_WRITING);
        issue(1'h1, {rv[15:13], 7'h03}, rv[9:0]);
        chk(got.cmd, lcd_pkg::LCD_CMD_BST);
        chk(probe(1), lcd_pkg::LCD_B_ACTIVE);
        issue(1'h1, {bsel[2:0], rv[15:14], rv[13], 4'hB}, rv[25:16]);
        chk(got.ab, rv[13]);
        wait_for(2, 32'h0);
      end
    end
    act();
    pwr(1'h0);
    wait_for(0, lcd_pkg::LCD_D_ACT_PD);
    pwr(1'h1);
    wait_for(0, lcd_pkg::LCD_D_NORMAL);
    issue(1'h1, 10'h01B, rv[9:0]);
    wait_for(2, 32'h0);
    fork
      issue(1'h1, {rv[5:0], 4'h0}, rv[15:6]);
      wait_for(0, lcd_pkg::LCD_D_MR_WRITING);
    join
    wait_for(0, lcd_pkg::LCD_D_NORMAL);
    issue(1'h1, {rv[5:0], 4'hC}, rv[15:6]);
    chk(got.cmd, lcd_pkg::LCD_CMD_REFAB);
    fork
      i_ctl.send(1'h1, 1'h0, {rv[5:0], 4'h8}, rv[15:6]);
      wait_for(3, 32'h1);
    join
    wait_for(0, lcd_pkg::LCD_D_NORMAL);
    issue(1'h1, {rv[5:0], 4'h4}, rv[15:6]);
    chk(got.cmd, lcd_pkg::LCD_CMD_REFPB);
    bsel = rv[5:3];
    wait_for(1, lcd_pkg::LCD_B_REFRESHING);
    wait_for(2, 32'h0);
    i_ctl.send(1'h0, 1'h0, {rv[5:0], 4'hC}, rv[15:6]);
    wait_for(0, lcd_pkg::LCD_D_SELF_REF);
    pwr(1'h1);
    wait_for(0, lcd_pkg::LCD_D_NORMAL);
    i_ctl.send(1'h0, 1'h0, {rv[6:0], 3'h3}, rv[15:6]);
    wait_for(0, lcd_pkg::LCD_D_DEEP_PD);
    pwr(1'h1);
    wait_for(0, lcd_pkg::LCD_D_POWER_ON);
    tally_and_finish();
  end
endmodule : lcd_cmd_decode_tb_top
`default_nettype wire
